/* File: core/pie_pkg.sv */
package pie_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int          PIE_DW              = 32;
  localparam int          PIE_AW              = 4;
  localparam logic [3:0]  PIE_OFS_STATUS      = 4'h0;
  localparam logic [3:0]  PIE_OFS_EN_SET      = 4'h4;
  localparam logic [3:0]  PIE_OFS_EN_CLEAR    = 4'h8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          PIE_SW_IRQ_LSB      = 24;
  localparam int          PIE_SW_IRQ_N        = 4;
  localparam int          PIE_PARITY_ERR_BIT  = 6;
  localparam int          PIE_SYSTEM_ERR_BIT  = 5;
  localparam int          PIE_MASTER_ABT_BIT  = 2;
  localparam int          PIE_TARGET_ABT_BIT  = 1;

  // implemented bits: 27..24, 6, 5, 2, 1; every other bit is reserved
  localparam logic [31:0] PIE_IMPL_MASK       = 32'h0f00_0066;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] PIE_EN_RESET        = 32'h0000_0000;
  localparam logic [31:0] PIE_STATUS_RESET    = 32'h0000_0000;
  localparam logic [31:0] PIE_DAT_RESET       = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing, in core_clk cycles
  // ----------------------------------------------------------------
  localparam int          PIE_ACK_LATENCY     = 1;

  // ----------------------------------------------------------------
  // state of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] status;
    logic [31:0] enable;
    logic [31:0] rdata;
    logic        ack;
    logic        irq;
  } pie_state_t;

endpackage

/* File: core/pie_irq_enable.sv */
// How it works
// RULE_01 - irq line high when any status bit and its enable bit are both set
// RULE_02 - enable register has no direct write; only set and clear registers change it
// RULE_03 - writing one to enable-set sets the matching enable bit
// RULE_04 - writing one to enable-clear clears the matching enable bit
// RULE_05 - zero data bits in set or clear writes leave enable bits unchanged
// RULE_06 - reading enable-set returns the current enable register
// RULE_07 - reading enable-clear returns status ANDed with enables, the masked source
// RULE_08 - four software interrupt enables sit in bits 27 down to 24
// RULE_09 - bit 6 is the parity error enable
// RULE_10 - bit 5 is the system error enable
// RULE_11 - bit 2 is the master abort enable
// RULE_12 - bit 1 is the target abort enable
// RULE_13 - reserved bits read zero and ignore writes
// RULE_14 - all enable bits are zero after reset
// RULE_15 - irq is a level and drops once the masked status is zero
`timescale 1ns/10ps
`default_nettype none

module pie_irq_enable
  import pie_pkg::*;
(
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  // wishbone classic slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [PIE_AW-1:0]      wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [PIE_DW-1:0]      wb_dat_i,
  output var  logic [PIE_DW-1:0]      wb_dat_o,
  output var  logic                   wb_ack_o,
  // status events, one-cycle pulses from core_clk logic
  input  wire logic [PIE_SW_IRQ_N-1:0] sw_irq_event,
  input  wire logic                   parity_err_event,
  input  wire logic                   system_err_event,
  input  wire logic                   master_abort_event,
  input  wire logic                   target_abort_event,
  // interrupt to the local processor
  output var  logic                   proc_irq_line
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pie_state_t state_q;
  pie_state_t state_d;

  logic [31:0] byte_mask;
  logic [31:0] event_vec;
  logic [31:0] wr_bits;
  logic        bus_req;
  logic        wr_commit;
  logic        hit_status;
  logic        hit_set;
  logic        hit_clear;

  // ----------------------------------------------------------------
  // byte lanes
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PIE_DW; gi++) begin : g_lane
      assign byte_mask[gi] = wb_sel_i[gi/8];
    end
  endgenerate

  // ----------------------------------------------------------------
  // event placement
  // ----------------------------------------------------------------
  always_comb begin
    event_vec = 32'h0000_0000;
    event_vec[PIE_SW_IRQ_LSB +: PIE_SW_IRQ_N] = sw_irq_event; // RULE_08
    event_vec[PIE_PARITY_ERR_BIT]             = parity_err_event; // RULE_09
    event_vec[PIE_SYSTEM_ERR_BIT]             = system_err_event; // RULE_10
    event_vec[PIE_MASTER_ABT_BIT]             = master_abort_event; // RULE_11
    event_vec[PIE_TARGET_ABT_BIT]             = target_abort_event; // RULE_12
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign bus_req    = wb_cyc_i & wb_stb_i;
  // writes land on the edge where the master sees ack, not before
  assign wr_commit  = bus_req & wb_we_i & state_q.ack;
  assign hit_status = (wb_adr_i == PIE_OFS_STATUS);
  assign hit_set    = (wb_adr_i == PIE_OFS_EN_SET);
  assign hit_clear  = (wb_adr_i == PIE_OFS_EN_CLEAR);
  // reserved bits and masked-off lanes never reach the registers
  assign wr_bits    = wb_dat_i & byte_mask & PIE_IMPL_MASK; // RULE_13

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;

    // ack one cycle after the request, then low for a cycle
    state_d.ack = bus_req & ~state_q.ack;

    // enable register: only the set and clear ports touch it
    if (wr_commit && hit_set) begin
      state_d.enable = state_q.enable | wr_bits; // RULE_02 RULE_03 RULE_05
    end else if (wr_commit && hit_clear) begin
      state_d.enable = state_q.enable & ~wr_bits; // RULE_02 RULE_04 RULE_05
    end

    // sticky status, write one to clear; a new event beats the clear
    if (wr_commit && hit_status) begin
      state_d.status = state_q.status & ~wr_bits;
    end
    state_d.status = (state_d.status | event_vec) & PIE_IMPL_MASK;

    // read data captured with ack so it is stable while ack is high
    if (bus_req && !state_q.ack && !wb_we_i) begin
      if (hit_set) begin
        state_d.rdata = state_q.enable & PIE_IMPL_MASK; // RULE_06 RULE_13
      end else if (hit_clear) begin
        state_d.rdata = state_q.status & state_q.enable & PIE_IMPL_MASK; // RULE_07
      end else if (hit_status) begin
        state_d.rdata = state_q.status & PIE_IMPL_MASK;
      end else begin
        // unmapped offsets answer with zero
        state_d.rdata = PIE_DAT_RESET;
      end
    end

    // level output follows the registered masked status
    state_d.irq = |(state_d.status & state_d.enable); // RULE_01 RULE_15
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q.status <= PIE_STATUS_RESET;
      state_q.enable <= PIE_EN_RESET; // RULE_14
      state_q.rdata  <= PIE_DAT_RESET;
      state_q.ack    <= 1'b0;
      state_q.irq    <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign wb_dat_o      = state_q.rdata;
  assign wb_ack_o      = state_q.ack;
  assign proc_irq_line = state_q.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence set_write_s;
    bus_req && wb_we_i && wb_ack_o && hit_set;
  endsequence

  sequence clear_write_s;
    bus_req && wb_we_i && wb_ack_o && hit_clear;
  endsequence

  sequence read_ack_s(logic hit);
    bus_req && !wb_we_i && wb_ack_o && hit;
  endsequence

  sequence status_clear_s;
    bus_req && wb_we_i && wb_ack_o && hit_status;
  endsequence

  sequence read_take_s;
    bus_req && !wb_we_i && !wb_ack_o;
  endsequence

  // irq mirrors the masked status in every cycle
  irq_level_a : assert property ( // RULE_01
    @(posedge core_clk) disable iff (reset)
    proc_irq_line == |(state_q.status & state_q.enable))
    else $error("irq line does not match masked status");

  // once masked status is gone the line is already low
  irq_drop_a : assert property ( // RULE_15
    @(posedge core_clk) disable iff (reset)
    ((state_q.status & state_q.enable) == 32'h0000_0000) |-> !proc_irq_line)
    else $error("irq line held with no masked status");

  // enables move only on an acked set or clear write
  en_guard_a : assert property ( // RULE_02
    @(posedge core_clk) disable iff (reset)
    !(wr_commit && (hit_set || hit_clear)) |=> $stable(state_q.enable))
    else $error("enable changed without set or clear write");

  set_bits_a : assert property ( // RULE_03
    @(posedge core_clk) disable iff (reset)
    set_write_s |=> ((state_q.enable & $past(wr_bits)) == $past(wr_bits)))
    else $error("set write did not set enable bits");

  clear_bits_a : assert property ( // RULE_04
    @(posedge core_clk) disable iff (reset)
    clear_write_s |=> ((state_q.enable & $past(wr_bits)) == 32'h0000_0000))
    else $error("clear write did not clear enable bits");

  zero_keep_a : assert property ( // RULE_05
    @(posedge core_clk) disable iff (reset)
    (set_write_s or clear_write_s) |=>
      ((state_q.enable & ~$past(wr_bits)) == ($past(state_q.enable) & ~$past(wr_bits))))
    else $error("zero data bit altered an enable bit");

  set_read_a : assert property ( // RULE_06
    @(posedge core_clk) disable iff (reset)
    read_ack_s(hit_set) |-> (wb_dat_o == state_q.enable))
    else $error("enable-set read is not the enable register");

  clear_read_a : assert property ( // RULE_07
    @(posedge core_clk) disable iff (reset)
    read_ack_s(hit_clear) |-> (wb_dat_o == ($past(state_q.status) & state_q.enable)))
    else $error("enable-clear read is not the masked status");

  sw_field_a : assert property ( // RULE_08
    @(posedge core_clk) disable iff (reset)
    (set_write_s and (wb_dat_i[27:24] == 4'hf) and (wb_sel_i[3] == 1'b1))
      |=> (state_q.enable[27:24] == 4'hf))
    else $error("software enable field not at bits 27 to 24");

  err_field_a : assert property ( // RULE_09 RULE_10
    @(posedge core_clk) disable iff (reset)
    (set_write_s and (wb_dat_i[6:5] == 2'h3) and wb_sel_i[0])
      |=> (state_q.enable[6:5] == 2'h3))
    else $error("error enables not at bits 6 and 5");

  abort_field_a : assert property ( // RULE_11 RULE_12
    @(posedge core_clk) disable iff (reset)
    (clear_write_s and (wb_dat_i[2:1] == 2'h3) and wb_sel_i[0])
      |=> (state_q.enable[2:1] == 2'h0))
    else $error("abort enables not at bits 2 and 1");

  reserved_zero_a : assert property ( // RULE_13
    @(posedge core_clk) disable iff (reset)
    ((state_q.enable & ~PIE_IMPL_MASK) == 32'h0000_0000) &&
      ((wb_dat_o & ~PIE_IMPL_MASK) == 32'h0000_0000))
    else $error("reserved bit is not zero");

  reset_zero_a : assert property ( // RULE_14
    @(posedge core_clk) disable iff (reset)
    $fell(reset) |-> (state_q.enable == 32'h0000_0000) && !proc_irq_line)
    else $error("enables not zero after reset");

  ack_pulse_a : assert property (
    @(posedge core_clk) disable iff (reset)
    (bus_req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse one cycle after request");

  event_wins_a : assert property (
    @(posedge core_clk) disable iff (reset)
    (|event_vec) |=> ((state_q.status & $past(event_vec)) == $past(event_vec)))
    else $error("status event lost");

  // unmapped offsets answer with zero data
  unmapped_read_a : assert property ( // RULE_13
    @(posedge core_clk) disable iff (reset)
    read_ack_s(!(hit_set || hit_clear || hit_status)) |-> (wb_dat_o == 32'h0000_0000))
    else $error("unmapped read is not zero");

  // plain status read shows the unmasked sticky bits
  status_read_a : assert property (
    @(posedge core_clk) disable iff (reset)
    read_ack_s(hit_status) |-> (wb_dat_o == $past(state_q.status)))
    else $error("status read is not the status register");

  // a one clears the sticky bit unless an event lands with it
  status_w1c_a : assert property (
    @(posedge core_clk) disable iff (reset)
    status_clear_s |=>
      ((state_q.status & $past(wr_bits) & ~$past(event_vec)) == 32'h0000_0000))
    else $error("status write one did not clear");

  // status writes never reach the enables
  status_keep_a : assert property ( // RULE_02
    @(posedge core_clk) disable iff (reset)
    status_clear_s |=> $stable(state_q.enable))
    else $error("status write changed enables");

  // data only in reserved bits changes nothing
  reserved_wr_a : assert property ( // RULE_13
    @(posedge core_clk) disable iff (reset)
    (set_write_s and ((wb_dat_i & PIE_IMPL_MASK) == 32'h0000_0000)) |=>
      $stable(state_q.enable))
    else $error("reserved write changed enables");

  // a lane with sel low is not written
  set_lane_a : assert property (
    @(posedge core_clk) disable iff (reset)
    (set_write_s and !wb_sel_i[3]) |=>
      (state_q.enable[27:24] == $past(state_q.enable[27:24])))
    else $error("set write touched a deselected lane");

  clear_lane_a : assert property (
    @(posedge core_clk) disable iff (reset)
    (clear_write_s and !wb_sel_i[0]) |=>
      (state_q.enable[7:0] == $past(state_q.enable[7:0])))
    else $error("clear write touched a deselected lane");

  // masked status present means the line is up
  irq_on_a : assert property ( // RULE_01
    @(posedge core_clk) disable iff (reset)
    (|(state_q.status & state_q.enable)) |-> proc_irq_line)
    else $error("irq line low with masked status");

  // read data only moves when a read is taken
  rdata_hold_a : assert property (
    @(posedge core_clk) disable iff (reset)
    !read_take_s |=> $stable(wb_dat_o))
    else $error("read data moved without a read");

  // no request, no answer
  ack_idle_a : assert property (
    @(posedge core_clk) disable iff (reset)
    !bus_req |=> !wb_ack_o)
    else $error("ack without a request");

  // ack never stands two cycles
  ack_gap_a : assert property (
    @(posedge core_clk) disable iff (reset)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for two cycles");

  sw_clear_field_a : assert property ( // RULE_08
    @(posedge core_clk) disable iff (reset)
    (clear_write_s and (wb_dat_i[27:24] == 4'hf) and wb_sel_i[3])
      |=> (state_q.enable[27:24] == 4'h0))
    else $error("software enables not cleared at bits 27 to 24");

  err_clear_field_a : assert property ( // RULE_09 RULE_10
    @(posedge core_clk) disable iff (reset)
    (clear_write_s and (wb_dat_i[6:5] == 2'h3) and wb_sel_i[0])
      |=> (state_q.enable[6:5] == 2'h0))
    else $error("error enables not cleared at bits 6 and 5");

  abort_set_field_a : assert property ( // RULE_11 RULE_12
    @(posedge core_clk) disable iff (reset)
    (set_write_s and (wb_dat_i[2:1] == 2'h3) and wb_sel_i[0])
      |=> (state_q.enable[2:1] == 2'h3))
    else $error("abort enables not set at bits 2 and 1");

  // clearing every live enable drops the line at once
  irq_en_drop_a : assert property ( // RULE_15
    @(posedge core_clk) disable iff (reset)
    (clear_write_s and ((wr_bits & state_q.enable) == state_q.enable))
      |=> !proc_irq_line)
    else $error("irq line held after enables cleared");

  // an enabled event raises the line on the next edge
  event_irq_a : assert property ( // RULE_01
    @(posedge core_clk) disable iff (reset)
    (!wr_commit && (|(event_vec & state_q.enable))) |=> proc_irq_line)
    else $error("enabled event did not raise irq line");

endmodule

`default_nettype wire

/* File: verif/pie_event_src.sv */
`timescale 1ns/10ps
`default_nettype none

module pie_event_src (
  // clock and control
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       run,
  // event pulses: sw[3:0], parity, system, master, target
  output var  logic [7:0] events
);
  integer seed = 32'he10a;
  // sparse one-cycle pulses so status fills a few bits at a time
  always @(posedge core_clk) begin
    if (reset || !run) events <= 8'h00;
    else events <= 8'($random(seed) & $random(seed) & $random(seed));
  end
endmodule

`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module testbench
  import pie_pkg::*;
;
  logic core_clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, run = 0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, rd, st, en, m;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, proc_irq_line;
  logic [7:0] ev;
  integer seed = 32'he10a;
  int fail_count = 0, tests_run = 0, cycles = 0;

  pie_irq_enable dut (.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sw_irq_event(ev[7:4]), .parity_err_event(ev[3]),
    .system_err_event(ev[2]), .master_abort_event(ev[1]), .target_abort_event(ev[0]),
    .proc_irq_line(proc_irq_line));
  pie_event_src src (.core_clk(core_clk), .reset(reset), .run(run), .events(ev));

  initial forever #5 core_clk = ~core_clk;

  // ------------------------------------------------------------
  // reference model, updated at the edge the write is acked
  // ------------------------------------------------------------
  function automatic logic [31:0] lanes(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction
  assign m = dat & lanes(sel) & PIE_IMPL_MASK;
  always @(posedge core_clk) begin
    if (reset) begin
      st <= 32'h0;
      en <= 32'h0;
    end else begin
      if (cyc && stb && we && wb_ack_o && adr == PIE_OFS_EN_SET) en <= en | m;
      if (cyc && stb && we && wb_ack_o && adr == PIE_OFS_EN_CLEAR) en <= en & ~m;
      st <= (st & ~((cyc && stb && we && wb_ack_o && adr == PIE_OFS_STATUS) ? m : 32'h0))
        | {4'h0, ev[7:4], 17'h0, ev[3:2], 2'b00, ev[1:0], 1'b0};
    end
  end
  function automatic logic [31:0] exp_rd(input logic [3:0] a);
    return a == PIE_OFS_EN_SET ? en : a == PIE_OFS_EN_CLEAR ? (st & en) :
      a == PIE_OFS_STATUS ? st : 32'h0;
  endfunction

  // level irq follows the masked status every settled cycle
  always @(negedge core_clk) if (!reset) `CHK("irq", |(st & en), proc_irq_line)

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  // ------------------------------------------------------------
  // bus access and closing
  // ------------------------------------------------------------
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge core_clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= s;
    // only the global cycle ceiling ends a hung access
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 0; stb <= 0;
  endtask
  task automatic chk_rd(input logic [3:0] a);
    wb(0, a, 32'h0, 4'hf);
    `CHK("rdata", exp_rd(a), rd)
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    int b;
    repeat (10) @(posedge core_clk);
    reset <= 0;
    @(posedge core_clk);
    chk_rd(PIE_OFS_EN_SET);
    chk_rd(PIE_OFS_EN_CLEAR);
    // each of the 32 bits alone, set then cleared, then all ones to unmapped offset 4'hc
    for (int i = 0; i < 32; i++) begin
      wb(1, PIE_OFS_EN_SET, 32'h1 << i, 4'hf);
      chk_rd(PIE_OFS_EN_SET);
      wb(1, PIE_OFS_EN_CLEAR, 32'h1 << i, 4'hf);
      chk_rd(PIE_OFS_EN_SET);
    end
    wb(1, 4'hc, 32'hffff_ffff, 4'hf);
    chk_rd(4'hc);
    chk_rd(PIE_OFS_EN_SET);
    // random set and clear traffic with events running
    for (int k = 0; k < 40; k++) begin
      run <= 1;
      b = $random(seed);
      wb(1, b[0] ? PIE_OFS_EN_SET : PIE_OFS_EN_CLEAR, $random(seed), b[7:4]);
      if (b[2:1] == 2'b00) wb(1, PIE_OFS_STATUS, $random(seed), 4'hf);
      run <= 0;
      repeat (2) @(posedge core_clk);
      chk_rd(PIE_OFS_EN_SET);
      chk_rd(PIE_OFS_EN_CLEAR);
    end
    // all enabled, then clearing status drops the line
    wb(1, PIE_OFS_EN_SET, 32'hffff_ffff, 4'hf);
    run <= 1;
    repeat (20) @(posedge core_clk);
    run <= 0;
    chk_rd(PIE_OFS_EN_CLEAR);
    wb(1, PIE_OFS_STATUS, 32'hffff_ffff, 4'hf);
    chk_rd(PIE_OFS_EN_CLEAR);
    chk_rd(PIE_OFS_STATUS);
    // reset in mid-run with everything enabled
    wb(1, PIE_OFS_EN_SET, 32'hffff_ffff, 4'hf);
    reset <= 1;
    repeat (3) @(posedge core_clk);
    reset <= 0;
    @(posedge core_clk);
    chk_rd(PIE_OFS_EN_SET);
    chk_rd(PIE_OFS_EN_CLEAR);
    results();
  end
endmodule

`default_nettype wire
